// ### logic/eips_pkg.sv
/*
 * Constants for the edge interrupt pulse shaper: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 25 MHz clock and a 32-bit APB register bus.
 */
package eips_pkg;

    localparam int ADDR_W = 12;

    // Byte addresses of the registers.
    localparam logic [11:0] OFF_TIMING = 12'h340;
    localparam logic [11:0] OFF_CTRL = 12'h350;
    localparam logic [11:0] OFF_STATUS = 12'h354;
    localparam logic [11:0] OFF_CLEAR = 12'h358;
    localparam logic [11:0] OFF_ENABLE = 12'h35c;

    // Field layout of the timing register.
    localparam int SPACE_LSB = 24;
    localparam int SPACE_W = 8;
    localparam int HOLD_LSB = 0;
    localparam int HOLD_W = 16;

    // Values after reset.
    localparam logic [15:0] HOLD_RESET = 16'h000f;
    localparam logic [7:0] SPACE_RESET = 8'h00;

    // Control register: bit 0 selects level mode.
    localparam int CTRL_LEVEL_BIT = 0;

    // Status bits: edge request seen, pulse issued, request held back.
    localparam int STS_W = 3;
    localparam int STS_SEEN = 0;
    localparam int STS_ISSUED = 1;
    localparam int STS_HELD = 2;

    // Microframe length and its least cycle count at the clock rate.
    localparam int CLK_PERIOD_NS = 40;
    localparam int UFRAME_NS = 125000;
    localparam int UFRAME_CYCLES = (UFRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int UF_CNT_W = 12;

endpackage

// ### logic/eips_shaper_if.sv
/*
 * Interface between the register block and the pulse shaper.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface eips_shaper_if;
    logic [15:0] hold_cycles;
    logic [7:0] spacing;
    logic level_mode;
    logic req;
    logic line;
    logic pulse_start;
    logic edge_seen;
    logic held;

    modport ctrl (
        output hold_cycles, spacing, level_mode, req,
        input line, pulse_start, edge_seen, held
    );
    modport shaper (
        input hold_cycles, spacing, level_mode, req,
        output line, pulse_start, edge_seen, held
    );
endinterface

`default_nettype wire

// ### logic/eips_shaper.sv
/*
 * Pulse shaper: turns rising edges of the request into pulses of a set
 * length, spaced by a minimum number of microframes, or passes the
 * request straight through in level mode.
 * Assumes the request comes from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none

module eips_shaper (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Link to the register block
    eips_shaper_if.shaper sh
);

    logic req_prev_q;
    logic pending_q;
    logic pending_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic [7:0] gap_q;
    logic [7:0] gap_d;
    logic [eips_pkg::UF_CNT_W-1:0] uf_cnt_q;
    logic line_q;
    logic start_q;
    logic seen_q;
    logic held_q;

    wire rise = sh.req & ~req_prev_q & ~sh.level_mode;
    wire busy = (hold_q != 16'h0000) | (gap_q != 8'h00);
    wire uf_tick = (uf_cnt_q == eips_pkg::UF_CNT_W'(eips_pkg::UFRAME_CYCLES - 1));
    // Zero spacing leaves only pulse end as gate.
    wire start = ~sh.level_mode & pending_q & ~busy;
    wire [15:0] hold_load = (sh.hold_cycles == 16'h0000) ? 16'h0001 : sh.hold_cycles;

    // Pending request is held until its pulse starts; level mode drops it.
    assign pending_d = ~sh.level_mode & (rise | (pending_q & ~start));

    assign hold_d = sh.level_mode ? 16'h0000 :
                    start ? hold_load :
                    (hold_q != 16'h0000) ? hold_q - 16'h0001 : 16'h0000;

    // Spacing counted in microframes from assertion.
    assign gap_d = sh.level_mode ? 8'h00 :
                   start ? sh.spacing :
                   (uf_tick && gap_q != 8'h00) ? gap_q - 8'h01 : gap_q;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            req_prev_q <= 1'b0;
            pending_q <= 1'b0;
            hold_q <= 16'h0000;
            gap_q <= 8'h00;
            uf_cnt_q <= '0;
            line_q <= 1'b0;
            start_q <= 1'b0;
            seen_q <= 1'b0;
            held_q <= 1'b0;
        end
        else
        begin
            req_prev_q <= sh.req;
            pending_q <= pending_d;
            hold_q <= hold_d;
            gap_q <= gap_d;
            // The microframe divider restarts with each pulse so a full
            // microframe elapses before the first decrement.
            uf_cnt_q <= (start || uf_tick) ? '0 : uf_cnt_q + 1'b1;
            line_q <= sh.level_mode ? sh.req : (hold_d != 16'h0000);
            start_q <= start;
            seen_q <= rise;
            held_q <= rise & (pending_q | busy);
        end
    end

    assign sh.line = line_q;
    assign sh.pulse_start = start_q;
    assign sh.edge_seen = seen_q;
    assign sh.held = held_q;

endmodule

`default_nettype wire

// ### logic/eips_top.sv
/*
 * Edge interrupt pulse shaper with its APB register block and a status
 * interrupt built from sticky event bits.
 * Registers, one 32-bit word each:
 *   0x340 timing: spacing in microframes [31:24], hold cycles [15:0].
 *   0x350 control: bit 0 selects level mode.
 *   0x354 status, read only: edge seen, pulse issued, request held back.
 *   0x358 clear, write only: ones clear the matching status bits.
 *   0x35c enable: status bits that may raise the status interrupt.
 * Unmapped addresses answer with an error and read as zero.
 * Assumes the interrupt request comes from logic on the same clock,
 * that APB runs on ref_clk_in and that software writes zeros to the
 * reserved bits of the timing register.
 */
// Functional notes
// - Edge pulses spaced by programmed microframes.
// - Spacing ignored in level mode.
// - Zero spacing issues pulses as soon as the previous pulse ends.
// - Edge pulse lasts programmed clock cycles, one cycle when zero.
// - Reset: hold fifteen, all else zero.
`timescale 1ns/10ps
`default_nettype none

module eips_top (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [eips_pkg::ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Interrupt request and shaped line
    input wire logic irq_req_in,
    output logic irq_line_out,
    // Status interrupt
    output logic sts_irq_out
);

    logic [15:0] hold_q;
    logic [7:0] space_q;
    logic level_q;
    logic [eips_pkg::STS_W-1:0] sts_q;
    logic [eips_pkg::STS_W-1:0] sts_d;
    logic [eips_pkg::STS_W-1:0] en_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    logic sts_irq_q;
    logic [15:0] hold_d;
    logic [7:0] space_d;
    logic level_d;
    logic [eips_pkg::STS_W-1:0] en_d;
    logic ready_d;
    logic err_d;
    logic [31:0] rdata_d;

    eips_shaper_if sif ();

    // Pulse shaping and spacing run in their own module.
    eips_shaper u_shaper (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .sh(sif.shaper)
    );

    // Stored settings and the raw request feed the shaper.
    assign sif.hold_cycles = hold_q;
    assign sif.spacing = space_q;
    assign sif.level_mode = level_q;
    assign sif.req = irq_req_in;

    // Address decode.
    wire sel_timing = (paddr_in == eips_pkg::OFF_TIMING);
    wire sel_ctrl = (paddr_in == eips_pkg::OFF_CTRL);
    wire sel_status = (paddr_in == eips_pkg::OFF_STATUS);
    wire sel_clear = (paddr_in == eips_pkg::OFF_CLEAR);
    wire sel_enable = (paddr_in == eips_pkg::OFF_ENABLE);
    wire mapped = sel_timing | sel_ctrl | sel_status | sel_clear | sel_enable;

    // A setup cycle starts a transfer; a write lands when the slave answers.
    wire setup = psel_in & ~penable_in;
    wire wr = psel_in & penable_in & pwrite_in & ready_q;

    // Reserved bits of the timing register read as zero.
    wire [31:0] timing_word = {space_q, 8'h00, hold_q};
    wire [31:0] ctrl_word = {31'h00000000, level_q};
    wire [31:0] sts_word = {{(32 - eips_pkg::STS_W){1'b0}}, sts_q};
    wire [31:0] en_word = {{(32 - eips_pkg::STS_W){1'b0}}, en_q};

    logic [31:0] rmux;
    always_comb
    begin
        rmux = 32'h00000000;
        if (sel_timing)
            rmux = timing_word;
        else if (sel_ctrl)
            rmux = ctrl_word;
        else if (sel_status)
            rmux = sts_word;
        else if (sel_enable)
            rmux = en_word;
        // The clear register is write only and reads as zero.
        else if (sel_clear)
            rmux = 32'h00000000;
    end

    // Event bits; a new event wins over a clear in the same cycle.
    wire [eips_pkg::STS_W-1:0] sts_evt = {sif.held, sif.pulse_start, sif.edge_seen};
    wire [eips_pkg::STS_W-1:0] sts_clr =
        (wr && sel_clear) ? pwdata_in[eips_pkg::STS_W-1:0] : '0;
    assign sts_d = sts_evt | (sts_q & ~sts_clr);

    // APB answers in the first access cycle, so there is no wait state.
    assign ready_d = setup;
    assign err_d = setup & ~mapped;
    // Read data stands only in the access cycle and is zero otherwise.
    assign rdata_d = (setup && !pwrite_in) ? rmux : 32'h00000000;

    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ready_q <= ready_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // Writes land at the access edge; unmapped writes change nothing.
    wire wr_timing = wr & sel_timing;
    wire wr_ctrl = wr & sel_ctrl;
    wire wr_enable = wr & sel_enable;

    assign space_d = wr_timing ?
                     pwdata_in[eips_pkg::SPACE_LSB +: eips_pkg::SPACE_W] : space_q;
    assign hold_d = wr_timing ?
                    pwdata_in[eips_pkg::HOLD_LSB +: eips_pkg::HOLD_W] : hold_q;
    // Control and enable words.
    assign level_d = wr_ctrl ? pwdata_in[eips_pkg::CTRL_LEVEL_BIT] : level_q;
    assign en_d = wr_enable ? pwdata_in[eips_pkg::STS_W-1:0] : en_q;

    // Reset values of the timing fields.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            hold_q <= eips_pkg::HOLD_RESET;
            space_q <= eips_pkg::SPACE_RESET;
        end
        else
        begin
            hold_q <= hold_d;
            space_q <= space_d;
        end
    end

    // Level mode and the enables start cleared.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            level_q <= 1'b0;
            en_q <= '0;
        end
        else
        begin
            level_q <= level_d;
            en_q <= en_d;
        end
    end

    // Status flags stay set until software clears them.
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            sts_q <= '0;
        end
        else
        begin
            sts_q <= sts_d;
        end
    end

    // The status interrupt uses the next enable, so a write to the enable
    // register takes effect in the same cycle as the stored bits.
    wire sts_irq_d = |(sts_d & en_d);
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            sts_irq_q <= 1'b0;
        end
        else
        begin
            sts_irq_q <= sts_irq_d;
        end
    end

    assign prdata_out = rdata_q;
    assign pready_out = ready_q;
    assign pslverr_out = err_q;
    // Shaped line straight from the shaper flop.
    assign irq_line_out = sif.line;
    assign sts_irq_out = sts_irq_q;

endmodule

`default_nettype wire

// ### tb/eips_assertions.sv
/* Port checks for eips_top, tracking timing and mode writes.
   Assumes it is bound to eips_top and sees its clock and reset. */
`timescale 1ns/10ps
`default_nettype none
module eips_assertions (
    // Watched ports
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic irq_req_in,
    input wire logic irq_line_out
);
    logic [15:0] hold_q;
    logic [7:0] space_q;
    logic lvl_q;
    logic [15:0] wid_q;
    logic [19:0] gap_q;
    wire logic wr_hit = psel_in && penable_in && pwrite_in && pready_out;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            hold_q <= eips_pkg::HOLD_RESET;
            space_q <= eips_pkg::SPACE_RESET;
            lvl_q <= 1'h0;
            wid_q <= 16'h0;
            gap_q <= 20'hfffff;
        end
        else
        begin
            if (wr_hit && paddr_in == eips_pkg::OFF_TIMING)
            begin
                hold_q <= pwdata_in[15:0];
                space_q <= pwdata_in[31:24];
            end
            if (wr_hit && paddr_in == eips_pkg::OFF_CTRL)
                lvl_q <= pwdata_in[0];
            wid_q <= irq_line_out ? wid_q + 16'h1 : 16'h0;
            gap_q <= $rose(irq_line_out) ? 20'h1 : gap_q + {19'h0, gap_q != 20'hfffff};
        end
    end
    a_gap_min: assert property (
        $rose(irq_line_out) && !lvl_q |-> gap_q >= 20'(space_q) * 20'(eips_pkg::UFRAME_CYCLES))
        else $error("edge pulses too close");
    a_level_pass: assert property (
        lvl_q && $past(lvl_q) |-> irq_line_out == $past(irq_req_in))
        else $error("level line does not follow request");
    a_zero_prompt: assert property (
        $rose(irq_req_in) && space_q == 8'h00 && !lvl_q && !irq_line_out
        && !$past(irq_line_out) |-> ##2 $rose(irq_line_out))
        else $error("pulse not prompt");
    a_pulse_len: assert property (
        $fell(irq_line_out) && !lvl_q |-> wid_q == (hold_q == 16'h0 ? 16'h1 : hold_q))
        else $error("pulse length wrong");
    a_timing_read: assert property (
        pready_out && psel_in && !pwrite_in && paddr_in == eips_pkg::OFF_TIMING
        |-> prdata_out == {space_q, 8'h00, hold_q})
        else $error("timing readback wrong");
    a_req_kept: assert property (
        $rose(irq_req_in) && !lvl_q && space_q == 8'h00 && hold_q < 16'h1f4
        |-> ##[1:600] $rose(irq_line_out))
        else $error("request lost");
endmodule
`default_nettype wire

// ### tb/eips_host_model.sv
/* Host interrupt input: counts pulses, their width and start spacing.
   Assumes the line is high while asserted. */
`timescale 1ns/10ps
`default_nettype none
module eips_host_model (
    input wire logic ref_clk_in,
    input wire logic irq_in,
    output int n_out,
    output int wid_out,
    output int gap_out
);
    int run = 0;
    int since = 0;
    initial n_out = 0;
    always @(posedge ref_clk_in)
    begin
        since <= since + 1;
        run <= irq_in ? run + 1 : 0;
        if (!irq_in && run > 0)
            wid_out <= run;
        if (irq_in && run == 0)
        begin
            n_out <= n_out + 1;
            gap_out <= since;
            since <= 1;
        end
    end
endmodule
`default_nettype wire

// ### tb/edge_interrupt_pulse_shaper_bench.sv
/* Self-checking bench for eips_top over APB.
   Assumes the host model and checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module edge_interrupt_pulse_shaper_bench;
    logic ref_clk_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic psel_in = 1'h0;
    logic penable_in = 1'h0;
    logic pwrite_in = 1'h0;
    logic [11:0] paddr_in = 12'h0;
    logic [31:0] pwdata_in = 32'h0;
    logic irq_req_in = 1'h0;
    logic [31:0] prdata_out, rd;
    logic pready_out, pslverr_out, irq_line_out, sts_irq_out, err;
    logic [15:0] h;
    int fails = 0;
    int check_count = 0;
    int seed = 32'h675e34b2;
    int cyc = 0;
    int n, w, g, n0;
    eips_top dut (.ref_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_req_in, .irq_line_out,
        .sts_irq_out);
    eips_host_model host (.ref_clk_in, .irq_in(irq_line_out), .n_out(n), .wid_out(w),
        .gap_out(g));
    initial forever #20 ref_clk_in = ~ref_clk_in;
    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge ref_clk_in);
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge ref_clk_in);
        penable_in <= 1'h1;
        do
            @(posedge ref_clk_in);
        while (pready_out !== 1'h1 && ++t < 20);
        rd = prdata_out;
        err = pslverr_out;
        chk("apb wait", 32'h1, {31'h0, t < 20});
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task automatic fire();
        @(posedge ref_clk_in) irq_req_in <= 1'h1;
        @(posedge ref_clk_in) irq_req_in <= 1'h0;
    endtask
    function automatic logic [31:0] exp_w(input logic [15:0] v);
        return v == 16'h0 ? 32'h1 : {16'h0, v};
    endfunction
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (6) @(posedge ref_clk_in);
        rst_n_in <= 1'h1;
        apb(1'h0, eips_pkg::OFF_TIMING, 32'h0);
        chk("timing reset", 32'hf, rd);
        apb(1'h0, 12'h100, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        chk("unmapped rd", 32'h0, rd);
        apb(1'h1, eips_pkg::OFF_ENABLE, 32'h7);
        for (int i = 0; i < 5; i++)
        begin
            h = i == 0 ? 16'h0 : i == 1 ? 16'h1 : i == 2 ? 16'hf : 16'h2 + 16'($random(seed) & 63);
            apb(1'h1, eips_pkg::OFF_TIMING, {16'h0, h});
            apb(1'h0, eips_pkg::OFF_TIMING, 32'h0);
            chk("timing rd", {16'h0, h}, rd);
            fire();
            @(posedge ref_clk_in);
            chk("line early", 32'h0, {31'h0, irq_line_out});
            @(posedge ref_clk_in);
            chk("line start", 32'h1, {31'h0, irq_line_out});
            repeat (h + 8) @(posedge ref_clk_in);
            chk("width", exp_w(h), w);
        end
        chk("pulses", 32'h5, n);
        apb(1'h1, eips_pkg::OFF_TIMING, {8'h1, 8'h0, 16'h4});
        repeat (3200) @(posedge ref_clk_in);
        n0 = n;
        fire();
        repeat (20 + ($random(seed) & 2047)) @(posedge ref_clk_in);
        fire();
        repeat (3300) @(posedge ref_clk_in);
        chk("held kept", n0 + 2, n);
        chk("gap", 32'h1, {31'h0, g >= eips_pkg::UFRAME_CYCLES});
        chk("sts irq", 32'h1, {31'h0, sts_irq_out});
        apb(1'h0, eips_pkg::OFF_STATUS, 32'h0);
        chk("status", 32'h7, rd);
        apb(1'h1, eips_pkg::OFF_CLEAR, 32'h7);
        @(posedge ref_clk_in);
        chk("sts clear", 32'h0, {31'h0, sts_irq_out});
        apb(1'h1, eips_pkg::OFF_ENABLE, 32'h0);
        fire();
        repeat (3300) @(posedge ref_clk_in);
        chk("masked", 32'h0, {31'h0, sts_irq_out});
        apb(1'h0, eips_pkg::OFF_STATUS, 32'h0);
        chk("seen", 32'h1, {31'h0, rd[0]});
        apb(1'h1, eips_pkg::OFF_CTRL, 32'h1);
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk_in) irq_req_in <= ~irq_req_in;
            repeat (2) @(posedge ref_clk_in);
            chk("level", {31'h0, irq_req_in}, {31'h0, irq_line_out});
        end
        print_verdict();
    end
endmodule
bind eips_top eips_assertions chk_i (.ref_clk_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .irq_req_in, .irq_line_out);
`default_nettype wire
